// ### hw/dbg_link_pkg.sv
// Constants and types for the single-wire background debug serial link.
// Assumes one bus clock (ref_clk, 10 MHz) and an asynchronous active-high reset.
package dbg_link_pkg;
   // ==========================================================
   // Bit timing in bus-clock cycles
   localparam int BIT_PERIOD    = 16;  // Nominal cycles per bit
   localparam int SAMPLE_CYCLE  = 10;  // Receive sample point
   localparam int ONE_PULSE     = 7;   // Speed-up pulse for a logic 1
   localparam int ZERO_LOW      = 13;  // Low time for a logic 0
   localparam int PULSE_LEN     = 1;   // Speed-up high drive length
   localparam int TIMEOUT_CYC   = 512; // Idle cycles between host edges
   localparam int OPCODE_BITS   = 8;   // Opcode length
   localparam int FIFO_DEPTH    = 8;   // Received byte buffer depth
   // ==========================================================
   // Reset values
   localparam logic [9:0] CNT_RESET   = 10'h000;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [2:0] SYNC_RESET  = 3'h7; // Idle line reads high
   // ==========================================================
   // Bit engine states
   typedef enum logic [1:0] {
      S_IDLE,   // Waiting for a host falling edge
      S_RECV,   // Host drives, device samples
      S_SEND,   // Device drives its bit
      S_WAIT    // Bit done, wait for line high
   } linkState_t;
endpackage

// ### hw/byte_stream_if.sv
// Valid/ready byte stream between link engine and buffer.
// Assumes both ends share ref_clk.
`timescale 1ns/100ps
interface byte_stream_if #(
   parameter int WIDTH = 8
);
   // ==========================================================
   logic [WIDTH-1:0] data;  // Payload
   logic             valid; // Producer has data
   logic             ready; // Consumer accepts
   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface

// ### hw/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; push and pop may coincide.
`timescale 1ns/100ps
module byte_fifo
   import dbg_link_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic   ref_clk,
   input  wire logic   rst,
   input  wire logic   flush,
   byte_stream_if.sink inStream,
   output logic [WIDTH-1:0] outData,
   output logic        outValid,
   input  wire logic   outReady
);
   localparam int AW = $clog2(DEPTH);
   // ==========================================================
   // State record
   typedef struct packed {
      logic [AW-1:0] wrPtr;  // Write index
      logic [AW-1:0] rdPtr;  // Read index
      logic [AW:0]   count;  // Fill level
   } fifoState_t;
   fifoState_t st;
   fifoState_t next_st;
   logic [WIDTH-1:0] mem [DEPTH];  // Storage words
   logic push;
   logic pop;
   // Handshakes: full refuses, empty hides output
   assign inStream.ready = (st.count != (AW+1)'(DEPTH));
   assign outValid       = (st.count != '0);
   assign push = inStream.valid & inStream.ready;
   assign pop  = outValid & outReady;
   assign outData = mem[st.rdPtr];
   // Next state
   always_comb begin
      next_st = st;
      if (flush) begin
         next_st = '0;
      end else begin
         if (push) next_st.wrPtr = (st.wrPtr == AW'(DEPTH-1)) ? '0 : st.wrPtr + 1'b1;
         if (pop)  next_st.rdPtr = (st.rdPtr == AW'(DEPTH-1)) ? '0 : st.rdPtr + 1'b1;
         next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Storage write, no reset needed for data words
   always_ff @(posedge ref_clk) begin
      if (push && !flush) begin
         mem[st.wrPtr] <= inStream.data;
      end
   end
endmodule

// ### hw/debug_link.sv
// Bit-level engine of the single-wire background debug link.
// Assumes the debug line pad resolves enable/level outside; host is asynchronous.
`timescale 1ns/100ps
module debug_link
   import dbg_link_pkg::*;
#(
   parameter int TIMEOUT = TIMEOUT_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       lineIn,
   output logic            lineOut,
   output logic            lineOe,
   input  wire logic       txRequest,
   input  wire logic [7:0] txByte,
   output logic            txBusy,
   output logic [7:0]      rxByte,
   output logic            rxValid,
   input  wire logic       rxReady,
   output logic            rxOverrun,
   output logic            linkTimeout,
   output logic            bitPhase,
   input  wire logic       backgroundActive,
   input  wire logic       busFree,
   input  wire logic       accessPending,
   output logic            accessGrant,
   output logic            stealCycle,
   output logic            firmwareAccept
);
   // ==========================================================
   // State record
   typedef struct packed {
      logic [2:0]  sync;      // Pin synchroniser, three stages
      logic        lineLevel; // Agreed line level
      linkState_t  state;     // Bit engine state
      logic [4:0]  bitCnt;    // Cycle in current bit
      logic [9:0]  idleCnt;   // Cycles since last host edge
      logic [7:0]  shift;     // Command shift register
      logic [3:0]  nBits;     // Bits gathered in byte
      logic [7:0]  txShift;   // Outgoing byte
      logic [3:0]  txLeft;    // Bits left to send
      logic        drive;     // Output enable
      logic        level;     // Driven level
      logic [7:0]  rxHold;    // Byte offered to buffer
      logic        rxPush;    // Offer pending
      logic        overrun;   // Byte lost to full buffer
      logic        timeout;   // Timeout pulse
      logic [7:0]  waitCnt;   // Dead cycle hunt counter
   } linkRegs_t;
   localparam int STEAL_LIMIT = 128; // Dead cycle search length
   linkRegs_t st;
   linkRegs_t next_st;
   logic fallEdge;
   logic curBit;
   byte_stream_if #(.WIDTH(8)) pushIf ();
   // Edge only once stages two and three agree low after a high level
   assign fallEdge = st.lineLevel && (st.sync[1] == st.sync[2]) && !st.sync[2];
   assign curBit   = st.txShift[7];
   assign pushIf.data  = st.rxHold;
   assign pushIf.valid = st.rxPush;
   // ==========================================================
   // Bit engine next state
   always_comb begin
      next_st = st;
      next_st.timeout = 1'b0;
      // Three-stage synchroniser; stage one feeds only stage two
      next_st.sync = {st.sync[1:0], lineIn};
      if (st.sync[1] == st.sync[2]) next_st.lineLevel = st.sync[2];
      if (pushIf.ready && st.rxPush) next_st.rxPush = 1'b0;
      // Dead cycle hunt for a pending memory access
      if (accessPending && !busFree && st.waitCnt != 8'(STEAL_LIMIT)) begin
         next_st.waitCnt = st.waitCnt + 8'h01;
      end else if (!accessPending || busFree) begin
         next_st.waitCnt = 8'h00;
      end
      // Idle counter runs between host falling edges
      if (fallEdge) begin
         next_st.idleCnt = CNT_RESET;
      end else if (st.idleCnt != 10'(TIMEOUT)) begin
         next_st.idleCnt = st.idleCnt + 10'h001;
      end
      if (st.idleCnt == 10'(TIMEOUT - 1) && !fallEdge) begin
         next_st.timeout = 1'b1;
         next_st.shift   = SHIFT_RESET;
         next_st.nBits   = 4'h0;
         next_st.txLeft  = 4'h0;
         next_st.drive   = 1'b0;
         next_st.state   = S_IDLE;
      end else begin
         case (st.state)
            S_IDLE: begin
               // Host falling edge opens every bit
               if (fallEdge) begin
                  next_st.bitCnt = 5'h01;
                  if (st.txLeft != 4'h0) begin
                     next_st.state = S_SEND;
                     if (!curBit) begin
                        next_st.drive = 1'b1;  // Hold low for a zero
                        next_st.level = 1'b0;
                     end
                  end else begin
                     next_st.state = S_RECV;
                  end
               end else if (txRequest && st.txLeft == 4'h0) begin
                  next_st.txShift = txByte;
                  next_st.txLeft  = 4'h8;
               end
            end
            S_RECV: begin
               next_st.bitCnt = st.bitCnt + 5'h01;
               if (st.bitCnt == 5'(SAMPLE_CYCLE)) begin
                  next_st.shift = {st.shift[6:0], st.lineLevel};
                  if (st.nBits == 4'(OPCODE_BITS - 1)) begin
                     // Full opcode offered to the receive buffer
                     next_st.nBits  = 4'h0;
                     next_st.rxHold = {st.shift[6:0], st.lineLevel};
                     next_st.rxPush = 1'b1;
                     if (st.rxPush && !pushIf.ready) next_st.overrun = 1'b1;
                  end else begin
                     next_st.nBits = st.nBits + 4'h1;
                  end
                  next_st.state = S_WAIT;
               end
            end
            S_SEND: begin
               next_st.bitCnt = st.bitCnt + 5'h01;
               if (curBit) begin
                  // Logic 1: brief high pulse
                  next_st.drive = (st.bitCnt == 5'(ONE_PULSE - 1));
                  next_st.level = 1'b1;
               end else if (st.bitCnt == 5'(ZERO_LOW)) begin
                  // Low through bit cycle thirteen, then speed-up high
                  next_st.level = 1'b1;
               end else if (st.bitCnt == 5'(ZERO_LOW + PULSE_LEN)) begin
                  next_st.drive = 1'b0;
               end
               if (st.bitCnt == 5'(ZERO_LOW + PULSE_LEN + 1)) begin
                  next_st.drive   = 1'b0;
                  next_st.txShift = {st.txShift[6:0], 1'b0};
                  next_st.txLeft  = st.txLeft - 4'h1;
                  next_st.state   = S_WAIT;
               end
            end
            S_WAIT: begin
               // Re-arm only once line is high again
               if (st.lineLevel) next_st.state = S_IDLE;
            end
            default: next_st.state = S_IDLE;
         endcase
      end
   end
   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st         <= '0;
         st.sync    <= SYNC_RESET;
         st.lineLevel <= 1'b1;
         st.state   <= S_IDLE;
      end else begin
         st <= next_st;
      end
   end
   // ==========================================================
   // Received opcode buffer
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) rxFifo (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .flush    (st.timeout),
      .inStream (pushIf),
      .outData  (rxByte),
      .outValid (rxValid),
      .outReady (rxReady)
   );
   // ==========================================================
   // Outputs
   assign lineOut     = st.level;
   assign lineOe      = st.drive;
   assign txBusy      = (st.txLeft != 4'h0);
   assign rxOverrun   = st.overrun;
   assign linkTimeout = st.timeout;
   assign bitPhase    = (st.state != S_IDLE);
   // Grant on a free cycle, steal when the hunt runs out
   assign accessGrant = accessPending && (busFree || st.waitCnt == 8'(STEAL_LIMIT));
   assign stealCycle  = accessPending && !busFree && st.waitCnt == 8'(STEAL_LIMIT);
   assign firmwareAccept = rxValid && backgroundActive;
   // ==========================================================
   // Checks
   a_no_drive_recv: assert property (@(posedge ref_clk) disable iff (rst)
      st.state == S_RECV |-> !lineOe) else $error("device drove during host bit");
   a_timeout_clears: assert property (@(posedge ref_clk) disable iff (rst)
      linkTimeout |-> st.shift == 8'h00 && st.nBits == 4'h0) else $error("timeout kept shift data");
   a_timeout_count: assert property (@(posedge ref_clk) disable iff (rst)
      linkTimeout |-> $past(st.idleCnt) == 10'(TIMEOUT - 1)) else $error("timeout at wrong count");
   a_sample_point: assert property (@(posedge ref_clk) disable iff (rst)
      st.state == S_RECV && st.bitCnt == 5'(SAMPLE_CYCLE) |=> st.shift[0] == $past(st.lineLevel))
      else $error("bit not sampled at point");
   a_one_pulse: assert property (@(posedge ref_clk) disable iff (rst)
      st.state == S_SEND && curBit && st.bitCnt == 5'(ONE_PULSE - 1) && !linkTimeout
      |=> lineOe && lineOut) else $error("one pulse missing");
   a_zero_low: assert property (@(posedge ref_clk) disable iff (rst)
      st.state == S_SEND && !curBit && st.bitCnt <= 5'(ZERO_LOW) |-> lineOe && !lineOut)
      else $error("zero not held low");
   a_firmware_gate: assert property (@(posedge ref_clk) disable iff (rst)
      firmwareAccept |-> backgroundActive) else $error("firmware accepted outside background");
   a_steal_bound: assert property (@(posedge ref_clk) disable iff (rst)
      stealCycle |-> st.waitCnt == 8'(STEAL_LIMIT) && !busFree) else $error("steal too early");
endmodule

// ### bench/host_pod.sv
// Behavioural debug pod at the far end of the single-wire debug line.
// Assumes the bench resolves the line from both enables with a pull-up.
`timescale 1ns/100ps
module host_pod (
   input  wire logic ref_clk,
   input  wire logic dbgLine,
   output logic      hostOut,
   output logic      hostOe
);
   // ==========================================================
   // Bit tasks, all driven just after a rising edge
   initial begin
      hostOut = 1'b1;
      hostOe  = 1'b0;
   end

   // Host to device bit; a zero stays low past the sample point
   task automatic sendBit(input logic b);
      @(posedge ref_clk);
      hostOut <= 1'b0; // Every bit opens with a fall
      hostOe  <= 1'b1;
      repeat (b ? 4 : 14) @(posedge ref_clk);
      hostOut <= 1'b1; // Active high speeds the rise
      repeat (b ? 11 : 1) @(posedge ref_clk);
      hostOe  <= 1'b0; // Drive only in own part of the bit
   endtask

   // Device to host bit; late sample tells how long a zero was held
   task automatic recvBit(output logic b, output logic late);
      @(posedge ref_clk);
      hostOut <= 1'b0;
      hostOe  <= 1'b1;
      repeat (4) @(posedge ref_clk); // Low well over two cycles
      hostOe  <= 1'b0; // Gone before the speed-up pulse
      repeat (6) @(posedge ref_clk);
      b = dbgLine; // Sample near cycle ten
      repeat (4) @(posedge ref_clk);
      late = dbgLine;
      // Long tail so the device has let go before the next fall
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic sendByte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) sendBit(v[i]); // MSB first
   endtask

   task automatic recvByte(output logic [7:0] v, output logic [7:0] late);
      for (int i = 7; i >= 0; i--) recvBit(v[i], late[i]);
   endtask
endmodule

// ### bench/debug_link_tb.sv
// Self-checking bench for the debug link engine and its receive buffer.
// Assumes host_pod as far end; timeout shortened to keep the run brief.
`timescale 1ns/100ps
module debug_link_tb
   import dbg_link_pkg::*;
;
   // ==========================================================
   // Signals
   localparam int TO_CYC = 40;  // Shortened idle timeout
   logic       ref_clk, rst, lineOut, lineOe, txRequest, txBusy;
   logic [7:0] txByte, rxByte, got, late;
   logic       rxValid, rxReady, rxOverrun, linkTimeout, bitPhase;
   logic       backgroundActive, busFree, accessPending;
   logic       accessGrant, stealCycle, firmwareAccept, hostOut, hostOe;
   int         errorCnt, compares, toCnt, oeBad, cycles, n;
   bit         txMode;
   // Pull-up wins only when nobody drives
   wire dbgLine = lineOe ? lineOut : (hostOe ? hostOut : 1'b1);

   debug_link #(.TIMEOUT(TO_CYC)) DUT (.ref_clk(ref_clk), .rst(rst), .lineIn(dbgLine),
      .lineOut(lineOut), .lineOe(lineOe), .txRequest(txRequest), .txByte(txByte),
      .txBusy(txBusy), .rxByte(rxByte), .rxValid(rxValid), .rxReady(rxReady),
      .rxOverrun(rxOverrun), .linkTimeout(linkTimeout), .bitPhase(bitPhase),
      .backgroundActive(backgroundActive), .busFree(busFree),
      .accessPending(accessPending), .accessGrant(accessGrant),
      .stealCycle(stealCycle), .firmwareAccept(firmwareAccept));
   host_pod HOST (.ref_clk(ref_clk), .dbgLine(dbgLine), .hostOut(hostOut), .hostOe(hostOe));

   // ==========================================================
   // Clock, monitors and watchdog
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Device drive outside its own bits and timeout pulses are counted
   always @(posedge ref_clk) begin
      if (!txMode && lineOe === 1'b1) oeBad++;
      if (linkTimeout === 1'b1) toCnt++;
   end
   initial begin
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles == 5000) begin
            errorCnt++;
            results;
         end
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic waitRx;
      for (int i = 0; i < 30 && rxValid !== 1'b1; i++) @(negedge ref_clk);
   endtask
   task automatic popOne;
      @(posedge ref_clk) rxReady <= 1'b1;
      @(posedge ref_clk) rxReady <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", compares, errorCnt);
      if (errorCnt == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_rx;
      @(negedge ref_clk) chk("phaseIdle", 8'h00, {7'h00, bitPhase});
      HOST.sendByte(8'ha5);
      waitRx;
      chk("rxByte", 8'ha5, rxByte);
      chk("fwIdle", 8'h00, {7'h00, firmwareAccept});
      @(posedge ref_clk) backgroundActive <= 1'b1;
      @(negedge ref_clk) chk("fwBg", 8'h01, {7'h00, firmwareAccept});
      popOne;
      backgroundActive <= 1'b0;
      chk("oeQuiet", 8'h00, oeBad[7:0]);
      // Host pause after a command before the next one
      repeat (150) @(posedge ref_clk);
      $display("test rx done");
   endtask

   task automatic t_tx;
      txMode = 1'b1;
      @(posedge ref_clk) begin
         txByte    <= 8'h3c;
         txRequest <= 1'b1;
      end
      @(posedge ref_clk) txRequest <= 1'b0;
      @(negedge ref_clk) chk("txBusy", 8'h01, {7'h00, txBusy});
      HOST.recvByte(got, late);
      chk("txData", 8'h3c, got);
      chk("zeroHold", 8'h3c, late);
      @(negedge ref_clk) chk("txIdle", 8'h00, {7'h00, txBusy});
      txMode = 1'b0;
      $display("test tx done");
   endtask

   task automatic t_timeout;
      HOST.sendBit(1'b1);
      HOST.sendBit(1'b0);
      HOST.sendBit(1'b1);
      n = toCnt;
      repeat (20) @(negedge ref_clk);
      chk("noEarlyTo", n[7:0], toCnt[7:0]);
      repeat (20) @(negedge ref_clk);
      chk("timeout", n[7:0] + 8'h01, toCnt[7:0]);
      HOST.sendByte(8'h81);
      waitRx;
      chk("afterTo", 8'h81, rxByte);
      popOne;
      $display("test timeout done");
   endtask

   task automatic t_fifo;
      // Eight buffered, one held for push; a tenth replaces the held byte
      for (int i = 0; i < 10; i++) HOST.sendByte(8'h10 + 8'(i));
      repeat (3) @(negedge ref_clk);
      chk("overrun", 8'h01, {7'h00, rxOverrun});
      @(posedge ref_clk) rxReady <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         @(negedge ref_clk) chk("fifoHead", (i < 8) ? 8'h10 + 8'(i) : 8'h19, rxByte);
         @(posedge ref_clk);
      end
      rxReady <= 1'b0;
      @(negedge ref_clk) chk("drained", 8'h00, {7'h00, rxValid});
      $display("test fifo done");
   endtask

   task automatic t_access;
      @(posedge ref_clk) begin
         accessPending <= 1'b1;
         busFree       <= 1'b1;
      end
      @(negedge ref_clk) chk("grantFree", 8'h01, {7'h00, accessGrant});
      chk("noSteal", 8'h00, {7'h00, stealCycle});
      @(posedge ref_clk) busFree <= 1'b0;
      n = 0;
      @(negedge ref_clk);
      while (stealCycle !== 1'b1 && n < 200) begin
         n++;
         @(negedge ref_clk);
      end
      // Steal only after the dead-cycle search has run out
      chk("stealWait", 8'h01, {7'h00, (n > 120 && n < 135)});
      @(posedge ref_clk) accessPending <= 1'b0;
      $display("test access done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      {txRequest, rxReady, backgroundActive, busFree, accessPending} = '0;
      txByte = 8'h00;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      t_rx;
      t_tx;
      t_timeout;
      t_fifo;
      t_access;
      results;
   end
endmodule
